// file: include/t2c_pkg.sv
package t2c_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [7:0] IDX_TCON   = 8'hc8;
  localparam logic [7:0] IDX_TMOD   = 8'hc9;
  localparam logic [7:0] IDX_RCL    = 8'hca;
  localparam logic [7:0] IDX_RCH    = 8'hcb;
  localparam logic [7:0] IDX_CNTL   = 8'hcc;
  localparam logic [7:0] IDX_CNTH   = 8'hcd;
  localparam logic [7:0] IDX_CAPA   = 8'h92;
  localparam logic [7:0] IDX_CAPB   = 8'h93;
  localparam logic [7:0] IDX_CAPC   = 8'h94;
  localparam logic [7:0] IDX_CAP0L  = 8'he0;
  localparam logic [7:0] IDX_CAPEND = 8'he5;
  localparam logic [7:0] IDX_IRQEN  = 8'he8;

  localparam int ADDR_W = 10;
  localparam int NCH    = 3;
  localparam int EDGE_W = 2 * NCH;

  // Field positions.
  localparam int TCON_FLAG   = 7;
  localparam int TCON_RUN    = 2;
  localparam int TCON_MODE   = 0;
  localparam int TMOD_RELOAD_EN = 7;
  localparam int TMOD_DIV    = 4;
  localparam int TMOD_CAPCLR = 3;
  localparam int TMOD_CMPCLR = 2;
  localparam int TMOD_TRIG   = 0;
  localparam int CAPA_EN     = 4;
  localparam int CAPA_FLAG   = 0;
  localparam int CAPB_EDGE   = 0;
  localparam int CAPC_FEN    = 4;
  localparam int CAPC_CAPCLR = 3;
  localparam int IRQ_TIMER   = 0;
  localparam int IRQ_CAP     = 2;
  localparam int IRQ_GLOBAL  = 7;

  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic        MODE_RELOAD  = 1'h0;
  localparam logic        MODE_COMPARE = 1'h1;
  localparam logic [1:0]  TRIG_OVF  = 2'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Glitch filter length in system clock cycles.
  localparam int FILTER_CYCLES = 4;

  typedef enum logic [1:0] {
    T2C_EDGE_RISE = 2'b00,
    T2C_EDGE_FALL = 2'b01,
    T2C_EDGE_ANY  = 2'b10
  } t2c_edge_t;

  // Last prescaler count before a tick for each divider code.
  function automatic logic [8:0] t2c_div_last(input logic [2:0] code);
    case (code)
      3'h0:    t2c_div_last = 9'h000;
      3'h1:    t2c_div_last = 9'h003;
      3'h2:    t2c_div_last = 9'h00f;
      3'h3:    t2c_div_last = 9'h01f;
      3'h4:    t2c_div_last = 9'h03f;
      3'h5:    t2c_div_last = 9'h07f;
      3'h6:    t2c_div_last = 9'h0ff;
      default: t2c_div_last = 9'h1ff;
    endcase
  endfunction

  function automatic logic [7:0] t2c_cap_idx(input int ch, input logic hi);
    t2c_cap_idx = IDX_CAP0L + 8'(2 * ch) + {7'h00, hi};
  endfunction

  function automatic logic t2c_mapped(input logic [7:0] idx);
    t2c_mapped = (idx == IDX_TCON) || (idx == IDX_TMOD) || (idx == IDX_RCL) ||
                 (idx == IDX_RCH) || (idx == IDX_CNTL) || (idx == IDX_CNTH) ||
                 (idx == IDX_CAPA) || (idx == IDX_CAPB) || (idx == IDX_CAPC) ||
                 (idx == IDX_IRQEN) || ((idx >= IDX_CAP0L) && (idx <= IDX_CAPEND));
  endfunction

endpackage

// file: rtl/t2c_capture_channel.sv
`timescale 1ns/1ps
module t2c_capture_channel (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Pin and configuration.
  input  wire logic       i_pin,
  input  wire logic       i_enable,
  input  wire logic       i_filter_en,
  input  wire logic [1:0] i_edge_sel,
  // Capture event pulse.
  output logic            o_event
);

  logic       sync1;
  logic       sync2;
  logic       filt_level;
  logic       prev_level;
  logic [1:0] filt_cnt;
  logic       edge_hit;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1 <= 1'h0;
      sync2 <= 1'h0;
    end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
    end
  end

  // A new level is accepted only after it has stood for the full filter length.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      filt_cnt   <= 2'h0;
      filt_level <= 1'h0;
    end else if (!i_filter_en || (sync2 == filt_level)) begin
      filt_cnt   <= 2'h0;
      filt_level <= sync2;
    end else if (filt_cnt == 2'(t2c_pkg::FILTER_CYCLES - 1)) begin
      filt_cnt   <= 2'h0;
      filt_level <= sync2;
    end else begin
      filt_cnt <= filt_cnt + 2'h1;
    end
  end

  always_comb begin
    unique case (t2c_pkg::t2c_edge_t'(i_edge_sel))
      t2c_pkg::T2C_EDGE_RISE: edge_hit = filt_level && !prev_level;
      t2c_pkg::T2C_EDGE_FALL: edge_hit = !filt_level && prev_level;
      default:                edge_hit = filt_level != prev_level;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_level <= 1'h0;
      o_event    <= 1'h0;
    end else begin
      prev_level <= filt_level;
      o_event    <= i_enable && edge_hit;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_filter;
    ($rose(filt_level) && $past(i_filter_en)) |->
      ($past(sync2, 1) && $past(sync2, 2) && $past(sync2, 3) && $past(sync2, 4));
  endproperty
  a_filter: assert property (p_filter) else $error("filter passed a short pulse");

endmodule // t2c_capture_channel

// file: rtl/t2c_timer2.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module t2c_timer2 (
  // Clock and reset.
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // AXI4-Lite write address.
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [t2c_pkg::ADDR_W-1:0]  i_awaddr,
  // AXI4-Lite write data.
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  // AXI4-Lite write response.
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  output logic [1:0]                       o_bresp,
  // AXI4-Lite read address.
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  input  wire logic [t2c_pkg::ADDR_W-1:0]  i_araddr,
  // AXI4-Lite read data.
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  output logic [31:0]                      o_rdata,
  output logic [1:0]                       o_rresp,
  // Capture pins.
  input  wire logic [t2c_pkg::NCH-1:0]     i_capture_input,
  // Interrupt requests.
  output logic                             o_timer_irq,
  output logic                             o_capture_irq
);

  localparam int NCH = t2c_pkg::NCH;

  // Bus state.
  logic       aw_full;
  logic       w_full;
  logic [7:0] aw_idx;
  logic [7:0] wd;
  logic       w_lane0;
  logic       wr_go;
  logic       wr_en;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;

  // Control and configuration.
  logic                  run_bit;
  logic                  compare_reload_select;
  logic                  overflow_match_flag;
  logic                  reload_enable;
  logic [2:0]            prescale_select;
  logic                  capture_auto_clear;
  logic                  match_auto_clear;
  logic [1:0]            reload_trigger_select;
  logic [7:0]            reload_compare_high;
  logic [7:0]            reload_compare_low;
  logic [NCH-1:0]        capture_channel_enable;
  logic [NCH-1:0]        capture_flag;
  logic [t2c_pkg::EDGE_W-1:0] capture_edge_select;
  logic [NCH-1:0]        noise_filter_enable;
  logic                  timer_irq_enable;
  logic                  capture_irq_enable;
  logic                  global_irq_enable;

  // Counter and capture state.
  logic [7:0]     count_high_byte;
  logic [7:0]     count_low_byte;
  logic [15:0]    count;
  logic [15:0]    reload_value;
  logic [15:0]    next_count;
  logic [7:0]     captured_high [NCH];
  logic [7:0]     captured_low  [NCH];
  logic [NCH-1:0] cap_evt;
  logic           any_cap;
  logic [8:0]     pre_cnt;
  logic           tick;
  logic           cnt_tick;
  logic           ovf;
  logic           match;
  logic           trig_cap;
  logic           reload_mode;

  assign wr_go        = aw_full && w_full && !o_bvalid;
  assign wr_en        = wr_go && w_lane0 && t2c_pkg::t2c_mapped(aw_idx);
  assign rd_idx       = i_araddr[t2c_pkg::ADDR_W-1:2];
  assign count        = {count_high_byte, count_low_byte};
  assign reload_value = {reload_compare_high, reload_compare_low};
  assign any_cap      = |cap_evt;
  assign reload_mode  = compare_reload_select == t2c_pkg::MODE_RELOAD;

  // Write address and data are held until both have arrived, then answered.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_awready <= 1'h1;
      o_wready  <= 1'h1;
      o_bvalid  <= 1'h0;
      o_bresp   <= t2c_pkg::RESP_OKAY;
      aw_full   <= 1'h0;
      w_full    <= 1'h0;
      aw_idx    <= t2c_pkg::RST_BYTE;
      wd        <= t2c_pkg::RST_BYTE;
      w_lane0   <= 1'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full   <= 1'h1;
        o_awready <= 1'h0;
        aw_idx    <= i_awaddr[t2c_pkg::ADDR_W-1:2];
      end
      if (i_wvalid && o_wready) begin
        w_full   <= 1'h1;
        o_wready <= 1'h0;
        wd       <= i_wdata[7:0];
        w_lane0  <= i_wstrb[0];
      end
      if (wr_go) begin
        aw_full  <= 1'h0;
        w_full   <= 1'h0;
        o_bvalid <= 1'h1;
        o_bresp  <= t2c_pkg::t2c_mapped(aw_idx) ? t2c_pkg::RESP_OKAY : t2c_pkg::RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'h0;
        o_awready <= 1'h1;
        o_wready  <= 1'h1;
      end
    end
  end

  always_comb begin
    rd_byte = t2c_pkg::RST_BYTE;
    case (rd_idx)
      t2c_pkg::IDX_TCON:  rd_byte = {overflow_match_flag, 4'h0, run_bit, 1'h0,
                                     compare_reload_select};
      t2c_pkg::IDX_TMOD:  rd_byte = {reload_enable, prescale_select, capture_auto_clear,
                                     match_auto_clear, reload_trigger_select};
      t2c_pkg::IDX_RCL:   rd_byte = reload_compare_low;
      t2c_pkg::IDX_RCH:   rd_byte = reload_compare_high;
      t2c_pkg::IDX_CNTL:  rd_byte = count_low_byte;
      t2c_pkg::IDX_CNTH:  rd_byte = count_high_byte;
      t2c_pkg::IDX_CAPA:  rd_byte = {1'h0, capture_channel_enable, 1'h0, capture_flag};
      t2c_pkg::IDX_CAPB:  rd_byte = {2'h0, capture_edge_select};
      t2c_pkg::IDX_CAPC:  rd_byte = {1'h0, noise_filter_enable, capture_auto_clear, 3'h0};
      t2c_pkg::IDX_IRQEN: rd_byte = {global_irq_enable, 4'h0, capture_irq_enable, 1'h0,
                                     timer_irq_enable};
      default:            rd_byte = t2c_pkg::RST_BYTE;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (rd_idx == t2c_pkg::t2c_cap_idx(i, 1'h0)) begin
        rd_byte = captured_low[i];
      end
      if (rd_idx == t2c_pkg::t2c_cap_idx(i, 1'h1)) begin
        rd_byte = captured_high[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_arready <= 1'h1;
      o_rvalid  <= 1'h0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= t2c_pkg::RESP_OKAY;
    end else begin
      if (i_arvalid && o_arready) begin
        o_arready <= 1'h0;
        o_rvalid  <= 1'h1;
        o_rdata   <= {24'h00_0000, rd_byte};
        o_rresp   <= t2c_pkg::t2c_mapped(rd_idx) ? t2c_pkg::RESP_OKAY : t2c_pkg::RESP_SLVERR;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid  <= 1'h0;
        o_arready <= 1'h1;
      end
    end
  end

  // Plain configuration fields; flags and counter bytes have their own processes.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_bit                <= 1'h0;
      compare_reload_select  <= t2c_pkg::MODE_RELOAD;
      reload_enable          <= 1'h0;
      prescale_select        <= 3'h0;
      capture_auto_clear     <= 1'h0;
      match_auto_clear       <= 1'h0;
      reload_trigger_select  <= t2c_pkg::TRIG_OVF;
      reload_compare_high    <= t2c_pkg::RST_BYTE;
      reload_compare_low     <= t2c_pkg::RST_BYTE;
      capture_channel_enable <= '0;
      capture_edge_select    <= '0;
      noise_filter_enable    <= '0;
      timer_irq_enable       <= 1'h0;
      capture_irq_enable     <= 1'h0;
      global_irq_enable      <= 1'h0;
    end else if (wr_en) begin
      case (aw_idx)
        t2c_pkg::IDX_TCON: begin
          run_bit               <= wd[t2c_pkg::TCON_RUN];
          compare_reload_select <= wd[t2c_pkg::TCON_MODE];
        end
        t2c_pkg::IDX_TMOD: begin
          reload_enable         <= wd[t2c_pkg::TMOD_RELOAD_EN];
          prescale_select       <= wd[t2c_pkg::TMOD_DIV +: 3];
          capture_auto_clear    <= wd[t2c_pkg::TMOD_CAPCLR];
          match_auto_clear      <= wd[t2c_pkg::TMOD_CMPCLR];
          reload_trigger_select <= wd[t2c_pkg::TMOD_TRIG +: 2];
        end
        t2c_pkg::IDX_RCL:  reload_compare_low  <= wd;
        t2c_pkg::IDX_RCH:  reload_compare_high <= wd;
        t2c_pkg::IDX_CAPA: capture_channel_enable <= wd[t2c_pkg::CAPA_EN +: NCH];
        t2c_pkg::IDX_CAPB: capture_edge_select <= wd[t2c_pkg::CAPB_EDGE +: t2c_pkg::EDGE_W];
        t2c_pkg::IDX_CAPC: begin
          noise_filter_enable <= wd[t2c_pkg::CAPC_FEN +: NCH];
          capture_auto_clear  <= wd[t2c_pkg::CAPC_CAPCLR];
        end
        t2c_pkg::IDX_IRQEN: begin
          timer_irq_enable   <= wd[t2c_pkg::IRQ_TIMER];
          capture_irq_enable <= wd[t2c_pkg::IRQ_CAP];
          global_irq_enable  <= wd[t2c_pkg::IRQ_GLOBAL];
        end
        default: ;
      endcase
    end
  end

  // Prescaler: one-cycle tick every divided period while the timer runs.
  always_ff @(posedge i_clk) begin
    if (i_rst || !run_bit) begin
      pre_cnt <= 9'h000;
      tick    <= 1'h0;
    end else if (pre_cnt >= t2c_pkg::t2c_div_last(prescale_select)) begin
      pre_cnt <= 9'h000;
      tick    <= 1'h1;
    end else begin
      pre_cnt <= pre_cnt + 9'h001;
      tick    <= 1'h0;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    t2c_capture_channel u_chan (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_pin       (i_capture_input[g]),
      .i_enable    (capture_channel_enable[g]),
      .i_filter_en (noise_filter_enable[g]),
      .i_edge_sel  (capture_edge_select[2*g +: 2]),
      .o_event     (cap_evt[g])
    );
  end

  assign cnt_tick = tick && run_bit;
  assign ovf      = cnt_tick && (count == t2c_pkg::CNT_MAX);
  assign match    = cnt_tick && !reload_mode && (count == reload_value);
  assign trig_cap = (reload_trigger_select != t2c_pkg::TRIG_OVF) &&
                    cap_evt[2'(reload_trigger_select - 2'h1)];

  // Later assignments take priority: capture clear beats reload beats counting.
  always_comb begin
    next_count = count;
    if (cnt_tick) begin
      next_count = count + 16'h0001;
    end
    if (match && match_auto_clear) begin
      next_count = t2c_pkg::CNT_ZERO;
    end
    if (reload_mode && reload_enable &&
        ((ovf && (reload_trigger_select == t2c_pkg::TRIG_OVF)) || trig_cap)) begin
      next_count = reload_value;
    end
    if (reload_mode && capture_auto_clear && any_cap) begin
      next_count = t2c_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_low_byte  <= t2c_pkg::RST_BYTE;
      count_high_byte <= t2c_pkg::RST_BYTE;
    end else begin
      count_low_byte  <= (wr_en && aw_idx == t2c_pkg::IDX_CNTL) ? wd : next_count[7:0];
      count_high_byte <= (wr_en && aw_idx == t2c_pkg::IDX_CNTH) ? wd : next_count[15:8];
    end
  end

  // Hardware only sets the flags; a set in the same cycle as a software clear wins.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      overflow_match_flag <= 1'h0;
      capture_flag        <= '0;
    end else begin
      overflow_match_flag <= ((wr_en && aw_idx == t2c_pkg::IDX_TCON) ?
                              wd[t2c_pkg::TCON_FLAG] : overflow_match_flag) ||
                             ovf || match;
      capture_flag <= ((wr_en && aw_idx == t2c_pkg::IDX_CAPA) ?
                       wd[t2c_pkg::CAPA_FLAG +: NCH] : capture_flag) | cap_evt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NCH; i++) begin
        captured_low[i]  <= t2c_pkg::RST_BYTE;
        captured_high[i] <= t2c_pkg::RST_BYTE;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (cap_evt[i]) begin
          captured_low[i]  <= count_low_byte;
          captured_high[i] <= count_high_byte;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_timer_irq   <= 1'h0;
      o_capture_irq <= 1'h0;
    end else begin
      o_timer_irq   <= overflow_match_flag && timer_irq_enable && global_irq_enable;
      o_capture_irq <= (|capture_flag) && capture_irq_enable && global_irq_enable;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_ovf_reload;
    ovf && reload_mode && reload_enable && (reload_trigger_select == t2c_pkg::TRIG_OVF) &&
      !wr_en && !(capture_auto_clear && any_cap);
  endsequence

  sequence s_cap_clear;
    reload_mode && capture_auto_clear && any_cap && !wr_en;
  endsequence

  sequence s_div4_held;
    (tick && run_bit && prescale_select == 3'h1) ##1 (run_bit && prescale_select == 3'h1)[*4];
  endsequence

  property p_run_hold;
    (!run_bit && !wr_en && !any_cap) |=> (count == $past(count));
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("count moved while stopped");

  property p_ovf_flag;
    ovf |=> overflow_match_flag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");

  property p_ovf_wrap;
    (ovf && !wr_en && !any_cap && !(reload_mode && reload_enable &&
      reload_trigger_select == t2c_pkg::TRIG_OVF)) |=> (count == t2c_pkg::CNT_ZERO);
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap) else $error("counter did not wrap");

  property p_match_clear;
    (match && match_auto_clear && !wr_en) |=> (count == t2c_pkg::CNT_ZERO) && overflow_match_flag;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match clear failed");

  property p_reload;
    s_ovf_reload |=> (count == $past(reload_value));
  endproperty
  a_reload: assert property (p_reload) else $error("reload value not loaded");

  property p_cap_clear;
    s_cap_clear |=> (count == t2c_pkg::CNT_ZERO);
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("capture clear failed");

  property p_capture_copy;
    cap_evt[0] |=> ({captured_high[0], captured_low[0]} == $past(count)) && capture_flag[0];
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture copy wrong");

  property p_cap_irq;
    ((|capture_flag) && capture_irq_enable && global_irq_enable) |=> o_capture_irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing");

  property p_div4;
    s_div4_held |-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3);
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four spacing wrong");

endmodule // t2c_timer2

// file: tb/t2c_pin_src.sv
`timescale 1ns/1ps
// Holds one capture pin high for a set number of cycles; pins idle low.
module t2c_pin_src (
  // Request.
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [1:0] i_ch,
  input  wire logic [3:0] i_width,
  // Pins.
  output logic [2:0]      o_pins
);
  logic [3:0] left = 4'h0;
  initial o_pins = 3'h0;
  always @(posedge i_clk) begin
    if (i_go) begin
      left <= i_width;
      o_pins[i_ch] <= 1'b1;
    end else if (left > 4'h1) begin
      left <= left - 4'h1;
    end else begin
      left <= 4'h0;
      o_pins <= 3'h0;
    end
  end
endmodule // t2c_pin_src

// file: tb/timer2_capture_compare_tb_top.sv
`timescale 1ns/1ps
module timer2_capture_compare_tb_top;
  logic        clk, rst, awv, wv, bre, arv, rre, go, awr, wrd, bv, arr, rv, tirq, cirq;
  logic [9:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws, wid;
  logic [1:0]  ch, br, rr, s, bs;
  logic [2:0]  pins;
  logic [7:0]  v, x, r;
  int          fails, samples_checked;

  t2c_pin_src t2c_pin_src_i (.i_clk(clk), .i_go(go), .i_ch(ch), .i_width(wid), .o_pins(pins));
  t2c_timer2 t2c_timer2_i (
    .i_clk(clk), .i_rst(rst), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
    .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv),
    .i_bready(bre), .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
    .o_rvalid(rv), .i_rready(rre), .o_rdata(rd), .o_rresp(rr),
    .i_capture_input(pins), .o_timer_irq(tirq), .o_capture_irq(cirq));

  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a, w;
    a = 0;
    w = 0;
    @(posedge clk);
    {awv, wv, bre, ws} <= 7'h71;
    awa <= {idx, 2'h0};
    wd <= {24'h0, d};
    while (!(a && w)) begin
      @(posedge clk);
      if (awv && awr) begin
        a = 1;
        awv <= 0;
      end
      if (wv && wrd) begin
        w = 1;
        wv <= 0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    bs = br;
    bre <= 0;
  endtask

  task automatic rdt(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] e);
    @(posedge clk);
    arv <= 1;
    rre <= 1;
    ara <= {idx, 2'h0};
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rd[7:0];
    e = rr;
    rre <= 0;
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] q;
    rdt(idx, d, q);
    chk({22'h0, q, d}, {22'h0, t2c_pkg::RESP_OKAY, e});
  endtask

  task automatic pulse(input int n, input logic [3:0] w);
    @(posedge clk);
    go <= 1;
    ch <= 2'(n);
    wid <= w;
    @(posedge clk);
    go <= 0;
  endtask

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    {rst, awv, wv, bre, arv, rre, go} = 7'h40;
    {awa, ara, wd, ws, wid, ch} = '0;
    x = $urandom(75183);
    repeat (5) @(posedge clk);
    rst <= 0;
    rc(t2c_pkg::IDX_TCON, 8'h00);
    rc(t2c_pkg::IDX_TMOD, 8'h00);
    rdt(8'h00, v, s);
    chk({30'h0, s}, {30'h0, t2c_pkg::RESP_SLVERR});
    wr(8'h00, 8'h5a);
    chk({30'h0, bs}, {30'h0, t2c_pkg::RESP_SLVERR});
    wr(t2c_pkg::IDX_CNTL, 8'hff);
    chk({30'h0, bs}, {30'h0, t2c_pkg::RESP_OKAY});
    wr(t2c_pkg::IDX_CNTH, 8'hff);
    wr(t2c_pkg::IDX_IRQEN, 8'h81);
    wr(t2c_pkg::IDX_TCON, 8'h04);
    rc(t2c_pkg::IDX_TCON, 8'h84);
    chk(32'(tirq), 1);
    wr(t2c_pkg::IDX_TCON, 8'h00);
    rc(t2c_pkg::IDX_CNTH, 8'h00);
    repeat (2) @(posedge clk);
    chk(32'(tirq), 0);
    wr(t2c_pkg::IDX_RCL, 8'h05);
    wr(t2c_pkg::IDX_CNTL, 8'h00);
    wr(t2c_pkg::IDX_TMOD, 8'h04);
    wr(t2c_pkg::IDX_TCON, 8'h05);
    repeat (40) @(posedge clk);
    rc(t2c_pkg::IDX_TCON, 8'h85);
    wr(t2c_pkg::IDX_TCON, 8'h01);
    rdt(t2c_pkg::IDX_CNTL, v, s);
    chk(32'(v <= 8'd5), 1);
    wr(t2c_pkg::IDX_CNTL, 8'hff);
    wr(t2c_pkg::IDX_CNTH, x);
    wr(t2c_pkg::IDX_TMOD, 8'h10);
    wr(t2c_pkg::IDX_TCON, 8'h04);
    repeat (8) @(posedge clk);
    wr(t2c_pkg::IDX_TCON, 8'h00);
    rc(t2c_pkg::IDX_CNTH, x + 8'h01);
    // Ratios rise so that a running prescaler never sits above its new limit.
    for (int c = 1; c < 8; c++) begin
      wr(t2c_pkg::IDX_CNTL, 8'h00);
      wr(t2c_pkg::IDX_TMOD, 8'(c << 4));
      wr(t2c_pkg::IDX_TCON, 8'h04);
      repeat ((c == 1 ? 4 : 2 ** (c + 2)) * 8) @(posedge clk);
      wr(t2c_pkg::IDX_TCON, 8'h00);
      rdt(t2c_pkg::IDX_CNTL, v, s);
      chk(32'(v >= 8'd7 && v <= 8'd10), 1);
      rc(t2c_pkg::IDX_CNTL, v);
    end
    wr(t2c_pkg::IDX_IRQEN, 8'h84);
    for (int n = 0; n < 3; n++) begin
      x = $urandom;
      wr(t2c_pkg::IDX_CNTL, x);
      wr(t2c_pkg::IDX_CNTH, ~x);
      wr(t2c_pkg::IDX_CAPB, 8'(n << (2 * n)));
      wr(t2c_pkg::IDX_CAPA, 8'(16 << n));
      pulse(n, 15);
      repeat (4) @(posedge clk);
      rdt(t2c_pkg::IDX_CAPA, v, s);
      chk(32'(v[n]), 32'(n != 1));
      repeat (20) @(posedge clk);
      rc(t2c_pkg::IDX_CAPA, 8'(17 << n));
      rc(t2c_pkg::IDX_CAP0L + 8'(2 * n), x);
      rc(t2c_pkg::IDX_CAP0L + 8'(2 * n + 1), ~x);
      chk(32'(cirq), 1);
      wr(t2c_pkg::IDX_CAPA, 8'h00);
      repeat (2) @(posedge clk);
      chk(32'(cirq), 0);
    end
    wr(t2c_pkg::IDX_CAPC, 8'h10);
    wr(t2c_pkg::IDX_CAPB, 8'h00);
    wr(t2c_pkg::IDX_CAPA, 8'h10);
    pulse(0, 2);
    repeat (20) @(posedge clk);
    rc(t2c_pkg::IDX_CAPA, 8'h10);
    pulse(0, 6);
    repeat (20) @(posedge clk);
    rc(t2c_pkg::IDX_CAPA, 8'h11);
    wr(t2c_pkg::IDX_CAPA, 8'h70);
    for (int t = 1; t < 4; t++) begin
      r = $urandom;
      wr(t2c_pkg::IDX_RCL, r);
      wr(t2c_pkg::IDX_RCH, 8'h12);
      wr(t2c_pkg::IDX_CNTH, 8'h00);
      wr(t2c_pkg::IDX_TMOD, 8'(128 + t));
      pulse(t - 1, 6);
      repeat (12) @(posedge clk);
      rc(t2c_pkg::IDX_CNTL, r);
      rc(t2c_pkg::IDX_CNTH, 8'h12);
    end
    wr(t2c_pkg::IDX_TMOD, 8'h89);
    pulse(0, 6);
    repeat (12) @(posedge clk);
    rc(t2c_pkg::IDX_CNTH, 8'h00);
    rc(t2c_pkg::IDX_CAP0L + 8'h01, 8'h12);
    // Overflow as the reload trigger: the count restarts from the reload value.
    wr(t2c_pkg::IDX_RCL, 8'h00);
    wr(t2c_pkg::IDX_RCH, 8'h34);
    wr(t2c_pkg::IDX_CNTL, 8'hff);
    wr(t2c_pkg::IDX_CNTH, 8'hff);
    wr(t2c_pkg::IDX_TMOD, 8'h80);
    wr(t2c_pkg::IDX_TCON, 8'h04);
    rc(t2c_pkg::IDX_TCON, 8'h84);
    wr(t2c_pkg::IDX_TCON, 8'h00);
    rc(t2c_pkg::IDX_CNTH, 8'h34);
    print_verdict();
  end
endmodule // timer2_capture_compare_tb_top
